//--- logic/eew_pkg.sv
// What this block does
// R01: Byte writes and page writes up to sixteen bytes
// R02: Programming time independent of bytes loaded
// R03: Sensor accesses still served while programming
// R04: Master sends half select before writes
// R05: Protected quadrant write: data refused, no cycle
// R06: Protected: set refused, clear acknowledged with cycle
// R07: Unprotected: all commands acknowledged, cycle started
// R08: Control byte 1010, address bits, write bit
// R09: Word address then data, both acknowledged
// R10: Stop in tenth clock starts programming
// R11: Stop on other clocks starts nothing
// R12: Programming ignores bus; data committed in time
// R13: Master waits write cycle time after writes
// R14: Address counter advances per data byte
// R15: Up to fifteen more bytes, each acknowledged
// R16: Only low four address bits wrap
// R17: Half select cleared at reset, software reset
// R18: 6Ch lower, 6Eh upper, two acknowledged bytes
// R19: 6Dh acknowledged only when lower half selected
// R20: Set protection 0110MMM0 with high voltage
// R21: Refused protected data discards buffered bytes
package eew_pkg;
   localparam int CLOCK_HZ = 10_000_000;
   localparam int BUS_HZ = 400_000;
   localparam int WRITE_CYCLE_TIME_US = 50;
   // Longest time, so rounded down
   localparam logic [15:0] WR_COUNT = 16'(WRITE_CYCLE_TIME_US * (CLOCK_HZ / 1_000_000));
   localparam logic [7:0] QTR_COUNT = 8'(CLOCK_HZ / (4 * BUS_HZ));
   localparam int PAGE_BYTES = 16;
   localparam int MEM_BYTES = 512;
   localparam int FIFO_DEPTH = 2;
   localparam int MAX_BYTES = 18;
   localparam logic [3:0] ACK_SLOT = 4'h8;
   localparam logic [3:0] SLOT_END = 4'h9;
   localparam logic [3:0] STOP_SLOT = 4'h1;
   localparam logic [3:0] MEM_TYPE_ID = 4'ha;
   localparam logic [3:0] SENSOR_TYPE_ID = 4'h3;
   localparam logic [3:0] PROT_TYPE_ID = 4'h6;
   localparam logic [2:0] CLEAR_PROT_ID = 3'h3;
   localparam logic [7:0] HALF_LOWER_CMD = 8'h6c;
   localparam logic [7:0] HALF_UPPER_CMD = 8'h6e;
   localparam logic [7:0] HALF_QUERY_CMD = 8'h6d;
   localparam logic [7:0] GENERAL_CALL = 8'h00;
   localparam logic [7:0] SOFT_RESET_CMD = 8'h06;
   localparam logic [7:0] IDLE_BYTE = 8'hff;

   typedef enum logic [4:0] {
      D_IDLE = 5'b00001,
      D_CTRL = 5'b00010,
      D_ADDR = 5'b00100,
      D_DATA = 5'b01000,
      D_SKIP = 5'b10000
   } eew_dstate_t;

   typedef enum logic [5:0] {
      H_IDLE = 6'b000001,
      H_START = 6'b000010,
      H_LOAD = 6'b000100,
      H_BIT = 6'b001000,
      H_STOP = 6'b010000,
      H_WAIT = 6'b100000
   } eew_hstate_t;

   typedef enum logic [2:0] {
      K_NONE = 3'h0,
      K_MEM = 3'h1,
      K_HSEL = 3'h2,
      K_SETP = 3'h3,
      K_CLRP = 3'h4,
      K_GCALL = 3'h5
   } eew_kind_t;

   // Quadrant identifier to {valid, index}
   function automatic logic [2:0] eew_quad_of_id(input logic [2:0] id);
      case (id)
         3'h1: return 3'h4;
         3'h4: return 3'h5;
         3'h5: return 3'h6;
         3'h0: return 3'h7;
         default: return 3'h0;
      endcase
   endfunction
endpackage

//--- logic/eew_bus_if.sv
`timescale 1ns/1ps
// Open-drain data line: an enabled low output pulls it down
interface eew_bus_if;
   logic sclLine;
   logic hostSdaOut;
   logic hostSdaOe;
   logic devSdaOut;
   logic devSdaOe;
   logic hvLevel;
   logic sdaLine;

   assign sdaLine = !((hostSdaOe && !hostSdaOut) || (devSdaOe && !devSdaOut));

   modport host (
      output sclLine,
      output hostSdaOut,
      output hostSdaOe,
      output hvLevel,
      input sdaLine
   );

   modport dev (
      input sclLine,
      input sdaLine,
      input hvLevel,
      output devSdaOut,
      output devSdaOe
   );
endinterface

//--- logic/eew_device.sv
`timescale 1ns/1ps
module eew_device
   import eew_pkg::*;
#(
   parameter logic [2:0] DEV_SEL = 3'h0
) (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic sysCe,
   eew_bus_if.dev bus,
   input wire logic [8:0] rdAddr,
   output logic [7:0] rdData,
   output logic progBusy,
   output logic halfSelect,
   output logic [3:0] protMask,
   output logic sensorReq
);
   // ----------------------------------------
   // Pin synchronisers and bus events
   // ----------------------------------------
   logic [2:0] sclSync_q;
   logic [2:0] sdaSync_q;
   logic [1:0] hvSync_q;
   logic rise;
   logic fall;
   logic startEv;
   logic stopEv;

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         sclSync_q <= 3'h7;
         sdaSync_q <= 3'h7;
         hvSync_q <= 2'h0;
      end else if (sysCe) begin
         sclSync_q <= {sclSync_q[1:0], bus.sclLine};
         sdaSync_q <= {sdaSync_q[1:0], bus.sdaLine};
         hvSync_q <= {hvSync_q[0], bus.hvLevel};
      end
   end

   assign rise = sclSync_q[1] && !sclSync_q[2];
   assign fall = !sclSync_q[1] && sclSync_q[2];
   assign startEv = sclSync_q[1] && sclSync_q[2] && sdaSync_q[2] && !sdaSync_q[1];
   assign stopEv = sclSync_q[1] && sclSync_q[2] && !sdaSync_q[2] && sdaSync_q[1];

   // ----------------------------------------
   // Bit slot tracking
   // ----------------------------------------
   logic [3:0] bitCnt_q;
   logic [7:0] shift_q;
   logic ackPoint;
   logic slotEnd;

   // Count keeps running during programming so sensor traffic is still framed
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         bitCnt_q <= 4'h0;
         shift_q <= 8'h00;
      end else if (sysCe) begin
         if (startEv || stopEv) begin
            bitCnt_q <= 4'h0;
         end else if (rise) begin
            bitCnt_q <= bitCnt_q + 4'h1;
            if (bitCnt_q < ACK_SLOT) begin
               shift_q <= {shift_q[6:0], sdaSync_q[1]};
            end
         end else if (fall && bitCnt_q == SLOT_END) begin
            bitCnt_q <= 4'h0;
         end
      end
   end

   assign ackPoint = fall && bitCnt_q == ACK_SLOT;
   assign slotEnd = fall && bitCnt_q == SLOT_END;

   // ----------------------------------------
   // Protocol engine
   // ----------------------------------------
   eew_dstate_t state_q;
   eew_kind_t kind_q;
   eew_kind_t progKind_q;
   logic ackOe_q;
   logic good_q;
   logic armed_q;
   logic [7:0] addr_q;
   logic halfSel_q;
   logic [3:0] prot_q;
   logic [1:0] protQuad_q;
   logic [PAGE_BYTES-1:0] pageValid_q;
   logic sensorReq_q;
   logic progBusy_q;
   logic [15:0] progCnt_q;
   logic progDone;
   logic startProg;
   logic protHit;
   logic memLoad;
   logic [2:0] quadSel;

   assign quadSel = eew_quad_of_id(shift_q[3:1]);
   assign protHit = prot_q[{halfSel_q, addr_q[7]}];
   assign memLoad = ackPoint && state_q == D_DATA && kind_q == K_MEM && !protHit;
   assign startProg = stopEv && armed_q && bitCnt_q == STOP_SLOT && !progBusy_q; // R10 R11
   assign progDone = progBusy_q && progCnt_q == 16'h0000;

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_q <= D_IDLE;
         kind_q <= K_NONE;
         ackOe_q <= 1'b0;
         good_q <= 1'b0;
         armed_q <= 1'b0;
         addr_q <= 8'h00;
         halfSel_q <= 1'b0; // R17
         prot_q <= 4'h0;
         protQuad_q <= 2'h0;
         pageValid_q <= '0;
         sensorReq_q <= 1'b0;
      end else if (sysCe) begin
         sensorReq_q <= 1'b0;
         if (progDone) begin
            pageValid_q <= '0;
            if (progKind_q == K_SETP) begin
               prot_q[protQuad_q] <= 1'b1;
            end else if (progKind_q == K_CLRP) begin
               prot_q <= 4'h0;
            end
         end
         if (startEv) begin
            state_q <= D_CTRL;
            ackOe_q <= 1'b0;
            armed_q <= 1'b0;
            // A restarted load is abandoned, a pending commit is not
            if (!progBusy_q) begin
               pageValid_q <= '0;
            end
         end else if (stopEv) begin
            state_q <= D_IDLE;
            ackOe_q <= 1'b0;
            armed_q <= 1'b0;
            if (!startProg && !progBusy_q) begin
               pageValid_q <= '0; // R11
            end
         end else if (ackPoint) begin
            ackOe_q <= 1'b0;
            armed_q <= 1'b0;
            good_q <= 1'b0;
            unique case (state_q)
               D_CTRL: begin
                  if (shift_q[7:4] == SENSOR_TYPE_ID && shift_q[3:1] == DEV_SEL) begin
                     ackOe_q <= 1'b1; // R03
                     sensorReq_q <= 1'b1;
                     state_q <= D_SKIP;
                  end else if (progBusy_q) begin
                     state_q <= D_SKIP; // R12
                  end else if (shift_q == HALF_LOWER_CMD || shift_q == HALF_UPPER_CMD) begin
                     halfSel_q <= shift_q == HALF_UPPER_CMD; // R18
                     kind_q <= K_HSEL;
                     ackOe_q <= 1'b1;
                     state_q <= D_DATA;
                  end else if (shift_q == HALF_QUERY_CMD) begin
                     ackOe_q <= !halfSel_q; // R19
                     state_q <= D_SKIP;
                  end else if (shift_q == GENERAL_CALL) begin
                     kind_q <= K_GCALL;
                     ackOe_q <= 1'b1;
                     state_q <= D_DATA;
                  end else if (shift_q[7:4] == MEM_TYPE_ID && shift_q[3:1] == DEV_SEL
                               && !shift_q[0]) begin
                     kind_q <= K_MEM; // R08
                     ackOe_q <= 1'b1;
                     state_q <= D_ADDR;
                  end else if (shift_q[7:4] == PROT_TYPE_ID && !shift_q[0] && hvSync_q[1]) begin
                     if (shift_q[3:1] == CLEAR_PROT_ID) begin
                        kind_q <= K_CLRP; // R06 R07
                        ackOe_q <= 1'b1;
                        state_q <= D_ADDR;
                     end else if (quadSel[2] && !prot_q[quadSel[1:0]]) begin
                        kind_q <= K_SETP; // R07
                        protQuad_q <= quadSel[1:0];
                        ackOe_q <= 1'b1;
                        state_q <= D_ADDR;
                     end else begin
                        state_q <= D_SKIP; // R06
                     end
                  end else begin
                     state_q <= D_SKIP;
                  end
               end
               D_ADDR: begin
                  ackOe_q <= 1'b1; // R09 R05
                  if (kind_q == K_MEM) begin
                     addr_q <= shift_q;
                  end
                  state_q <= D_DATA;
               end
               D_DATA: begin
                  if (kind_q == K_MEM) begin
                     if (protHit) begin
                        pageValid_q <= '0; // R05 R21
                        state_q <= D_SKIP;
                     end else begin
                        ackOe_q <= 1'b1; // R15
                        pageValid_q[addr_q[3:0]] <= 1'b1;
                        addr_q[3:0] <= addr_q[3:0] + 4'h1; // R14 R16
                        good_q <= 1'b1;
                     end
                  end else begin
                     ackOe_q <= 1'b1;
                     good_q <= kind_q == K_SETP || kind_q == K_CLRP;
                     if (kind_q == K_GCALL && shift_q == SOFT_RESET_CMD) begin
                        halfSel_q <= 1'b0; // R17
                     end
                  end
               end
               D_IDLE, D_SKIP: begin
               end
            endcase
         end else if (slotEnd) begin
            ackOe_q <= 1'b0;
            armed_q <= good_q;
         end
      end
   end

   // ----------------------------------------
   // Self-timed programming
   // ----------------------------------------
   // Fixed count regardless of load size
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         progBusy_q <= 1'b0;
         progCnt_q <= 16'h0000;
         progKind_q <= K_NONE;
      end else if (sysCe) begin
         if (startProg) begin
            progBusy_q <= 1'b1; // R02
            progCnt_q <= WR_COUNT - 16'h0001;
            progKind_q <= kind_q;
         end else if (progDone) begin
            progBusy_q <= 1'b0;
         end else if (progBusy_q) begin
            progCnt_q <= progCnt_q - 16'h0001;
         end
      end
   end

   // ----------------------------------------
   // Page buffer and array
   // ----------------------------------------
   logic [7:0] pageBuf_q [PAGE_BYTES];
   logic [7:0] mem_q [MEM_BYTES];
   logic [7:0] rdData_q;

   always_ff @(posedge sys_clk) begin
      if (sysCe && memLoad) begin
         pageBuf_q[addr_q[3:0]] <= shift_q; // R01
      end
   end

   // Array only changes when the cycle ends
   always_ff @(posedge sys_clk) begin
      if (sysCe && progDone && progKind_q == K_MEM) begin
         for (int i = 0; i < PAGE_BYTES; i++) begin
            if (pageValid_q[i]) begin
               mem_q[{halfSel_q, addr_q[7:4], 4'(i)}] <= pageBuf_q[i]; // R12
            end
         end
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         rdData_q <= 8'h00;
      end else if (sysCe) begin
         rdData_q <= mem_q[rdAddr];
      end
   end

   assign bus.devSdaOut = 1'b0;
   assign bus.devSdaOe = ackOe_q;
   assign rdData = rdData_q;
   assign progBusy = progBusy_q;
   assign halfSelect = halfSel_q;
   assign protMask = prot_q;
   assign sensorReq = sensorReq_q;
endmodule

//--- logic/eew_host.sv
`timescale 1ns/1ps
module eew_host
   import eew_pkg::*;
(
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic sysCe,
   eew_bus_if.host bus,
   input wire logic cmdValid,
   output logic cmdReady,
   input wire logic [7:0] cmdCtrl,
   input wire logic [7:0] cmdAddr,
   input wire logic cmdHasAddr,
   input wire logic [4:0] cmdCount,
   input wire logic cmdFromFifo,
   input wire logic cmdHv,
   input wire logic cmdWaitWrite,
   input wire logic dataValid,
   output logic dataReady,
   input wire logic [7:0] dataIn,
   output logic rspValid,
   output logic [MAX_BYTES-1:0] rspAckMask
);
   // ----------------------------------------
   // Two-entry data buffer
   // ----------------------------------------
   logic [7:0] fifoMem_q [FIFO_DEPTH];
   logic fifoWr_q;
   logic fifoRd_q;
   logic [1:0] fifoCnt_q;
   logic push;
   logic pop;

   assign dataReady = fifoCnt_q != 2'(FIFO_DEPTH);
   assign push = dataValid && dataReady;

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         fifoWr_q <= 1'b0;
         fifoRd_q <= 1'b0;
         fifoCnt_q <= 2'h0;
      end else if (sysCe) begin
         fifoWr_q <= fifoWr_q ^ push;
         fifoRd_q <= fifoRd_q ^ pop;
         fifoCnt_q <= fifoCnt_q + 2'(push) - 2'(pop);
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sysCe && push) begin
         fifoMem_q[fifoWr_q] <= dataIn;
      end
   end

   // ----------------------------------------
   // Transfer sequencer
   // ----------------------------------------
   eew_hstate_t state_q;
   logic [1:0] sdaSync_q;
   logic [7:0] qtrCnt_q;
   logic [1:0] ph_q;
   logic tick;
   logic [7:0] txByte_q;
   logic [3:0] bitIdx_q;
   logic [4:0] byteIdx_q;
   logic [4:0] total_q;
   logic [4:0] dataStart_q;
   logic [7:0] addr_q;
   logic fromFifo_q;
   logic waitWrite_q;
   logic hv_q;
   logic sclOut_q;
   logic sdaOe_q;
   logic rsp_q;
   logic [MAX_BYTES-1:0] ackMask_q;
   logic [15:0] waitCnt_q;
   logic needFifo;

   assign tick = qtrCnt_q == QTR_COUNT - 8'h01;
   assign needFifo = fromFifo_q && byteIdx_q >= dataStart_q;
   assign pop = state_q == H_LOAD && needFifo && fifoCnt_q != 2'h0;
   assign cmdReady = state_q == H_IDLE;

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         sdaSync_q <= 2'h3;
      end else if (sysCe) begin
         sdaSync_q <= {sdaSync_q[0], bus.sdaLine};
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         qtrCnt_q <= 8'h00;
         ph_q <= 2'h0;
      end else if (sysCe) begin
         if (state_q == H_IDLE || state_q == H_LOAD) begin
            qtrCnt_q <= 8'h00;
            ph_q <= 2'h0;
         end else if (tick) begin
            qtrCnt_q <= 8'h00;
            ph_q <= ph_q + 2'h1;
         end else begin
            qtrCnt_q <= qtrCnt_q + 8'h01;
         end
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_q <= H_IDLE;
         txByte_q <= 8'h00;
         bitIdx_q <= 4'h0;
         byteIdx_q <= 5'h00;
         total_q <= 5'h00;
         dataStart_q <= 5'h00;
         addr_q <= 8'h00;
         fromFifo_q <= 1'b0;
         waitWrite_q <= 1'b0;
         hv_q <= 1'b0;
         sclOut_q <= 1'b1;
         sdaOe_q <= 1'b0;
         rsp_q <= 1'b0;
         ackMask_q <= '0;
         waitCnt_q <= 16'h0000;
      end else if (sysCe) begin
         rsp_q <= 1'b0;
         unique case (state_q)
            H_IDLE: begin
               if (cmdValid) begin
                  // Half select ahead of writes is up to the issuer R04
                  txByte_q <= cmdCtrl; // R08
                  addr_q <= cmdAddr;
                  dataStart_q <= 5'h01 + 5'(cmdHasAddr);
                  total_q <= 5'h01 + 5'(cmdHasAddr) + cmdCount; // R15
                  fromFifo_q <= cmdFromFifo;
                  waitWrite_q <= cmdWaitWrite;
                  hv_q <= cmdHv; // R20
                  byteIdx_q <= 5'h00;
                  bitIdx_q <= 4'h0;
                  ackMask_q <= '0;
                  state_q <= H_START;
               end
            end
            H_START: begin
               if (tick) begin
                  if (ph_q == 2'h1) begin
                     sdaOe_q <= 1'b1;
                  end else if (ph_q == 2'h2) begin
                     sclOut_q <= 1'b0;
                  end else if (ph_q == 2'h3) begin
                     state_q <= H_BIT;
                  end
               end
            end
            H_LOAD: begin
               // Stalls here until the buffer holds a byte
               if (!needFifo || fifoCnt_q != 2'h0) begin
                  if (needFifo) begin
                     txByte_q <= fifoMem_q[fifoRd_q];
                  end else if (byteIdx_q == 5'h01 && dataStart_q == 5'h02) begin
                     txByte_q <= addr_q; // R09
                  end else begin
                     txByte_q <= IDLE_BYTE;
                  end
                  bitIdx_q <= 4'h0;
                  state_q <= H_BIT;
               end
            end
            H_BIT: begin
               if (tick) begin
                  unique case (ph_q)
                     2'h0: sdaOe_q <= bitIdx_q != ACK_SLOT && !txByte_q[7];
                     2'h1: sclOut_q <= 1'b1;
                     2'h2: begin
                        if (bitIdx_q == ACK_SLOT) begin
                           ackMask_q[byteIdx_q] <= !sdaSync_q[1];
                        end
                     end
                     2'h3: begin
                        sclOut_q <= 1'b0;
                        txByte_q <= {txByte_q[6:0], 1'b1};
                        bitIdx_q <= bitIdx_q + 4'h1;
                        if (bitIdx_q == ACK_SLOT) begin
                           if (byteIdx_q == total_q - 5'h01) begin
                              state_q <= H_STOP;
                           end else begin
                              byteIdx_q <= byteIdx_q + 5'h01;
                              state_q <= H_LOAD;
                           end
                        end
                     end
                  endcase
               end
            end
            H_STOP: begin
               // Stop lands in the clock right after the last ack R10
               if (tick) begin
                  if (ph_q == 2'h0) begin
                     sdaOe_q <= 1'b1;
                  end else if (ph_q == 2'h1) begin
                     sclOut_q <= 1'b1;
                  end else if (ph_q == 2'h2) begin
                     sdaOe_q <= 1'b0;
                  end else begin
                     hv_q <= 1'b0;
                     rsp_q <= 1'b1;
                     waitCnt_q <= WR_COUNT;
                     state_q <= waitWrite_q ? H_WAIT : H_IDLE;
                  end
               end
            end
            H_WAIT: begin
               if (waitCnt_q == 16'h0001) begin
                  state_q <= H_IDLE; // R13
               end
               waitCnt_q <= waitCnt_q - 16'h0001;
            end
         endcase
      end
   end

   assign bus.sclLine = sclOut_q;
   assign bus.hostSdaOut = 1'b0;
   assign bus.hostSdaOe = sdaOe_q;
   assign bus.hvLevel = hv_q;
   assign rspValid = rsp_q;
   assign rspAckMask = ackMask_q;
endmodule

//--- verification/eew_bus_chk.sv
`timescale 1ns/1ps
module eew_bus_chk (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic sclLine,
   input wire logic hostSdaOut,
   input wire logic hostSdaOe,
   input wire logic devSdaOut,
   input wire logic devSdaOe,
   input wire logic hvLevel,
   input wire logic sdaLine
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   // ----------------------------------------
   // Wire checks
   // ----------------------------------------
   property p_rst_idle; $past(sys_rst) |-> sclLine && !devSdaOe && !hostSdaOe && !hvLevel; endproperty
   a_rst_idle: assert property (p_rst_idle) else $error("bus not idle after reset");
   property p_dev_low; devSdaOe |-> !devSdaOut && !sdaLine; endproperty
   a_dev_low: assert property (p_dev_low) else $error("device ack not pulling low");
   property p_host_low; hostSdaOe |-> !hostSdaOut; endproperty
   a_host_low: assert property (p_host_low) else $error("host drives data high");
   // Ack may only move while the clock is low, or it reads as start/stop
   property p_ack_edge; $changed(devSdaOe) |-> !sclLine; endproperty
   a_ack_edge: assert property (p_ack_edge) else $error("ack moved with clock high");
   // Both may pull low briefly after the clock falls; never while it is high
   property p_ack_host_off; devSdaOe && sclLine |-> !hostSdaOe; endproperty
   a_ack_host_off: assert property (p_ack_host_off) else $error("ack while host drives");
   property p_ack_hold; $rose(devSdaOe) |=> devSdaOe [*8]; endproperty
   a_ack_hold: assert property (p_ack_hold) else $error("ack too short");
   property p_ack_end; $rose(devSdaOe) |-> ##[9:1000] $fell(devSdaOe); endproperty
   a_ack_end: assert property (p_ack_end) else $error("ack never released");
   property p_scl_low; $fell(sclLine) |=> !sclLine [*5]; endproperty
   a_scl_low: assert property (p_scl_low) else $error("clock low phase short");
   property p_scl_high; $rose(sclLine) |=> sclLine [*8]; endproperty
   a_scl_high: assert property (p_scl_high) else $error("clock high phase short");
endmodule

//--- verification/eeprom_write_path_tb.sv
`timescale 1ns/1ps
module eeprom_write_path_tb;
   import eew_pkg::*;
   localparam logic [7:0] MEM_WR = {MEM_TYPE_ID, 3'h0, 1'b0};
   logic sys_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic sysCe = 1'b1;
   logic cmdValid = 1'b0, cmdHasAddr = 1'b0, cmdFromFifo = 1'b0, cmdHv = 1'b0;
   logic cmdWaitWrite = 1'b0, dataValid = 1'b0, tk = 1'b0;
   logic [7:0] cmdCtrl = 8'h00, cmdAddr = 8'h00, dataIn = 8'h00;
   logic [4:0] cmdCount = 5'h00;
   logic [8:0] rdAddr = 9'h000;
   logic cmdReady, dataReady, rspValid, progBusy, halfSelect, sensorReq;
   logic [MAX_BYTES-1:0] rspAckMask;
   logic [7:0] rdData;
   logic [3:0] protMask;
   logic [7:0] q[$];
   int error_cnt = 0, checks_done = 0, cyc = 0, busyCnt = 0, sensCnt = 0;
   eew_bus_if bus ();
   eew_host u_eew_host (.sys_clk, .sys_rst, .sysCe, .bus(bus), .cmdValid, .cmdReady, .cmdCtrl,
      .cmdAddr, .cmdHasAddr, .cmdCount, .cmdFromFifo, .cmdHv, .cmdWaitWrite, .dataValid,
      .dataReady, .dataIn, .rspValid, .rspAckMask);
   eew_device u_eew_device (.sys_clk, .sys_rst, .sysCe, .bus(bus), .rdAddr, .rdData,
      .progBusy, .halfSelect, .protMask, .sensorReq);
   eew_bus_chk u_eew_bus_chk (.sys_clk, .sys_rst, .sclLine(bus.sclLine),
      .hostSdaOut(bus.hostSdaOut), .hostSdaOe(bus.hostSdaOe), .devSdaOut(bus.devSdaOut),
      .devSdaOe(bus.devSdaOe), .hvLevel(bus.hvLevel), .sdaLine(bus.sdaLine));
   initial forever #50 sys_clk = ~sys_clk;
   // ----------------------------------------
   // Byte feeder and watchdog
   // ----------------------------------------
   // Queue outruns the two-entry buffer, so refusals happen on long loads
   always @(negedge sys_clk) tk = dataValid && dataReady;
   always @(posedge sys_clk) begin
      if (tk) q.delete(0);
      dataValid <= (q.size() > 0);
      dataIn <= (q.size() > 0) ? q[0] : 8'h00;
      cyc <= cyc + 1;
      if (progBusy === 1'b1) busyCnt <= busyCnt + 1;
      if (sensorReq === 1'b1) sensCnt <= sensCnt + 1;
      if (cyc == 40000) begin
         error_cnt++;
         end_sim();
      end
   end
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic chk(input string nm, input logic [17:0] exp, input logic [17:0] got);
      checks_done++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // Flags are {hasAddr, fromFifo, hv, waitWrite}
   task automatic cmd(input logic [7:0] c, a, input logic [3:0] f, input logic [4:0] n,
         input logic [17:0] exp);
      @(negedge sys_clk);
      while (cmdReady !== 1'b1) @(negedge sys_clk);
      @(posedge sys_clk);
      cmdValid <= 1'b1;
      cmdCtrl <= c;
      cmdAddr <= a;
      {cmdHasAddr, cmdFromFifo, cmdHv, cmdWaitWrite} <= f;
      cmdCount <= n;
      @(posedge sys_clk);
      cmdValid <= 1'b0;
      @(negedge sys_clk);
      while (rspValid !== 1'b1) @(negedge sys_clk);
      chk("ack mask", exp, rspAckMask);
   endtask
   task automatic wait_idle();
      @(negedge sys_clk);
      while (cmdReady !== 1'b1 || progBusy !== 1'b0) @(negedge sys_clk);
   endtask
   task automatic rd(input logic [8:0] a, input logic [7:0] exp);
      @(posedge sys_clk);
      rdAddr <= a;
      @(posedge sys_clk);
      @(negedge sys_clk);
      chk("array byte", 18'(exp), 18'(rdData));
   endtask
   task automatic end_sim();
      $display("checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // ----------------------------------------
   // Sequence
   // ----------------------------------------
   initial begin
      repeat (20) @(posedge sys_clk);
      sys_rst <= 1'b0;
      @(negedge sys_clk);
      chk("half select", 18'h0, 18'(halfSelect));
      cmd(HALF_QUERY_CMD, 8'h00, 4'h0, 5'h02, 18'h1);
      cmd(HALF_UPPER_CMD, 8'h00, 4'h0, 5'h02, 18'h7);
      chk("half select", 18'h1, 18'(halfSelect));
      cmd(HALF_QUERY_CMD, 8'h00, 4'h0, 5'h02, 18'h0);
      q.push_back(8'h5a);
      cmd(MEM_WR, 8'h80, 4'hd, 5'h01, 18'h7);
      wait_idle();
      rd(9'h180, 8'h5a);
      chk("busy length", 18'(WR_COUNT), 18'(busyCnt));
      q.push_back(SOFT_RESET_CMD);
      cmd(GENERAL_CALL, 8'h00, 4'h4, 5'h01, 18'h3);
      chk("half select", 18'h0, 18'(halfSelect));
      cmd(HALF_LOWER_CMD, 8'h00, 4'h0, 5'h02, 18'h7);
      chk("half select", 18'h0, 18'(halfSelect));
      for (int i = 0; i < 16; i++) q.push_back(8'h40 + 8'(i));
      cmd(MEM_WR, 8'h3e, 4'hc, 5'h10, 18'h3ffff);
      // Poll while programming: ignored, so no ack at all
      cmd(MEM_WR, 8'h00, 4'h0, 5'h00, 18'h0);
      wait_idle();
      chk("busy length", 18'(2 * WR_COUNT), 18'(busyCnt));
      for (int i = 0; i < 16; i++) rd({5'h03, 4'(14 + i)}, 8'h40 + 8'(i));
      cmd(8'h62, 8'h00, 4'ha, 5'h01, 18'h7);
      // Sensor traffic while the set is still programming
      cmd(8'h30, 8'h00, 4'h0, 5'h00, 18'h1);
      chk("busy", 18'h1, 18'(progBusy));
      chk("sensor pulses", 18'h1, 18'(sensCnt));
      wait_idle();
      chk("protect mask", 18'h1, 18'(protMask));
      cmd(8'h62, 8'h00, 4'hb, 5'h01, 18'h0);
      q.push_back(8'hee);
      cmd(MEM_WR, 8'h31, 4'hc, 5'h01, 18'h3);
      chk("busy", 18'h0, 18'(progBusy));
      rd(9'h031, 8'h43);
      cmd(8'h66, 8'h00, 4'hb, 5'h01, 18'h7);
      wait_idle();
      chk("protect mask", 18'h0, 18'(protMask));
      end_sim();
   end
endmodule
